/* File: inc/msmc_pkg.sv */
package msmc_pkg;

    // ****************************************
    // register indices, byte address = 4 * index
    // ****************************************
    localparam logic [7:0] IDX_PRIORITY_AND_MODE = 8'h3c;
    localparam logic [7:0] IDX_MEMORY_PLACEMENT  = 8'h3d;
    localparam logic [7:0] IDX_STARTUP_OPTIONS   = 8'h3f;

    // ****************************************
    // priority_and_mode fields
    // ****************************************
    localparam int PM_BOOT_BIT     = 7;
    localparam int PM_SPECIAL_BIT  = 6;
    localparam int PM_EXPAND_BIT   = 5;
    localparam int PM_VISIBLE_BIT  = 4;
    localparam int PM_PSEL_LSB     = 0;
    localparam logic [3:0] PM_PSEL_RESET = 4'h5;

    // ****************************************
    // startup_options fields
    // ****************************************
    localparam int SO_WDOG_DIS_BIT = 2;
    localparam int SO_ROM_BIT      = 1;
    localparam logic SO_WDOG_DIS_RESET = 1'b0;
    localparam logic SO_ROM_RESET      = 1'b1;

    // ****************************************
    // memory_placement fields
    // ****************************************
    localparam int MP_RAM_LSB = 4;
    localparam int MP_REG_LSB = 0;
    localparam logic [3:0] MP_RAM_RESET = 4'h0;
    localparam logic [3:0] MP_REG_RESET = 4'h0;

    // ****************************************
    // memory map
    // ****************************************
    localparam logic [3:0]  ROM_PAGE_EXPANDED = 4'h7;
    localparam logic [3:0]  ROM_PAGE_OTHER    = 4'hf;
    localparam logic [15:0] BOOT_FIRST        = 16'hbf40;
    localparam logic [15:0] BOOT_LAST         = 16'hbfff;
    localparam logic [7:0]  RAM_FIRST_LOW     = 8'h40;
    localparam logic [7:0]  RAM_LAST_LOW      = 8'hff;
    localparam logic [11:0] REG_LAST_LOW      = 12'h03f;

    // ****************************************
    // timing
    // ****************************************
    localparam int          WINDOW_BUS_CYCLES = 64;
    localparam logic [6:0]  WINDOW_COUNT      = 7'(WINDOW_BUS_CYCLES);
    localparam int          E_DIV_DEFAULT     = 4;

endpackage

/* File: core/msmc_config.sv */
`timescale 1ns/10ps
// Functional notes
// [RQ1] sample both straps during reset, hold them after reset releases
// [RQ2] straps B,A map to boot, special, expanded bits per mode table
// [RQ3] after reset strap A pin is open-drain low fetch strobe, first E cycle
// [RQ4] boot ROM enable writable only in special mode; maps BF40-BFFF
// [RQ5] special bit loads inverse of strap B; software may clear, never set
// [RQ6] expanded bit loads strap A; writable only while special bit set
// [RQ7] expanded modes: visibility bit drives internal read data outward
// [RQ8] single-chip modes: visibility bit zero runs E, one holds E low
// [RQ9] visibility bit resets one in test mode only; E always on at reset
// [RQ10] normal modes: protected bits written once within 64 bus cycles
// [RQ11] software writes protected registers before clearing special bit
// [RQ12] special bit clear: options register takes one write; watchdog on
// [RQ13] options bits 7..3 and 0 read zero
// [RQ14] watchdog disable clears at reset; one disables watchdog
// [RQ15] ROM enable forced one at reset; once normal, any time special
// [RQ16] ROM at 7000-7FFF if reset expanded, else F000-FFFF; code uses 7000-7FFF only after a normal expanded reset
// [RQ17] placement register takes single write in 64 E cycles, then read-only; code takes writes any time while special bit set
// [RQ18] RAM page field places RAM at x040-x0FF, resets to 0040
// [RQ19] register page field places 64-byte block at x000-x03F
// [RQ20] register block and RAM win over ROM
// [RQ21] register block wins over RAM
module msmc_config #(
    parameter int E_DIV = msmc_pkg::E_DIV_DEFAULT
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // wishbone slave
    input  wire logic        wbCycI,
    input  wire logic        wbStbI,
    input  wire logic        wbWeI,
    input  wire logic [9:0]  wbAdrI,
    input  wire logic [3:0]  wbSelI,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAckO,
    // strap pins, strap A doubles as fetch strobe
    input  wire logic        strapAPinIn,
    input  wire logic        strapBPinIn,
    output logic             strapAPinOut,
    output logic             strapAPinOe,
    // cpu side
    input  wire logic        opcodeFetch,
    input  wire logic        intReadAccess,
    input  wire logic [7:0]  intReadData,
    input  wire logic [15:0] cpuAddr,
    // external bus and E pin
    output logic      [7:0]  extDataOut,
    output logic             extDataOe,
    output logic             eClkOut,
    // decode and status
    output logic             selRegBlock,
    output logic             selRam,
    output logic             selRom,
    output logic             selBootRom,
    output logic             watchdogDisable,
    output logic             specialMode,
    output logic             expandedMode
);

    // ****************************************
    // strap synchronisers
    // ****************************************
    logic strapAMeta;
    logic strapASync;
    logic strapBMeta;
    logic strapBSync;

    always_ff @(posedge clk_sys) begin
        strapAMeta <= strapAPinIn;
        strapASync <= strapAMeta;
        strapBMeta <= strapBPinIn;
        strapBSync <= strapBMeta;
    end

    // ****************************************
    // E clock divider
    // ****************************************
    localparam int DW = $clog2(E_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(E_DIV - 1);
    localparam logic [DW-1:0] DIV_HALF = DW'(E_DIV / 2);

    logic [DW-1:0] divCnt_reg;
    logic          eTick;

    assign eTick = (divCnt_reg == DIV_LAST);

    always_ff @(posedge clk_sys) begin
        if (srst || eTick) begin
            divCnt_reg <= '0;
        end else begin
            divCnt_reg <= divCnt_reg + DW'(1);
        end
    end

    // ****************************************
    // protection window
    // ****************************************
    logic [6:0] windowCnt_reg;
    logic       windowOpen;

    assign windowOpen = (windowCnt_reg < msmc_pkg::WINDOW_COUNT);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            windowCnt_reg <= '0;
        end else if (eTick && windowOpen) begin
            windowCnt_reg <= windowCnt_reg + 7'd1;
        end
    end

    // ****************************************
    // bus decode
    // ****************************************
    logic       busReq;
    logic       wrLow;
    logic [7:0] regIdx;
    logic       hitMode;
    logic       hitPlace;
    logic       hitOpts;

    assign busReq   = wbCycI && wbStbI && !wbAckO;
    assign wrLow    = busReq && wbWeI && wbSelI[0];
    assign regIdx   = wbAdrI[9:2];
    assign hitMode  = (regIdx == msmc_pkg::IDX_PRIORITY_AND_MODE);
    assign hitPlace = (regIdx == msmc_pkg::IDX_MEMORY_PLACEMENT);
    assign hitOpts  = (regIdx == msmc_pkg::IDX_STARTUP_OPTIONS);

    // ****************************************
    // priority_and_mode register
    // ****************************************
    logic       bootEn_reg;
    logic       special_reg;
    logic       expand_reg;
    logic       visible_reg;
    logic [3:0] psel_reg;
    logic       resetExpanded_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            special_reg       <= !strapBSync;                 // [RQ1] [RQ2] [RQ5]
            expand_reg        <= strapASync;                  // [RQ2] [RQ6]
            bootEn_reg        <= !strapBSync && !strapASync;  // [RQ2]
            visible_reg       <= !strapBSync && strapASync;   // [RQ9]
            resetExpanded_reg <= strapBSync && strapASync;
            psel_reg          <= msmc_pkg::PM_PSEL_RESET;
        end else if (wrLow && hitMode) begin
            special_reg <= special_reg && wbDatI[msmc_pkg::PM_SPECIAL_BIT];  // [RQ5]
            if (special_reg) begin
                expand_reg <= wbDatI[msmc_pkg::PM_EXPAND_BIT];              // [RQ6]
            end
            bootEn_reg  <= special_reg && wbDatI[msmc_pkg::PM_SPECIAL_BIT]
                           && wbDatI[msmc_pkg::PM_BOOT_BIT];                // [RQ4]
            visible_reg <= wbDatI[msmc_pkg::PM_VISIBLE_BIT];
            psel_reg    <= wbDatI[msmc_pkg::PM_PSEL_LSB +: 4];
        end
    end

    // ****************************************
    // startup_options register
    // ****************************************
    logic wdogDis_reg;
    logic rom_present_reg;
    logic optsDone_reg;
    logic optsOk;

    assign optsOk = special_reg || (windowOpen && !optsDone_reg);  // [RQ10] [RQ12]

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wdogDis_reg  <= msmc_pkg::SO_WDOG_DIS_RESET;  // [RQ14]
            rom_present_reg    <= msmc_pkg::SO_ROM_RESET;       // [RQ15]
            optsDone_reg <= 1'b0;
        end else if (wrLow && hitOpts && optsOk) begin
            wdogDis_reg  <= wbDatI[msmc_pkg::SO_WDOG_DIS_BIT];  // [RQ14]
            rom_present_reg    <= wbDatI[msmc_pkg::SO_ROM_BIT];       // [RQ15]
            optsDone_reg <= 1'b1;                               // [RQ12]
        end
    end

    // ****************************************
    // memory_placement register
    // ****************************************
    logic [3:0] ramPage_reg;
    logic [3:0] regPage_reg;
    logic       placeDone_reg;
    logic       placeOk;

    assign placeOk = special_reg || (windowOpen && !placeDone_reg);  // [RQ10] [RQ17]

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ramPage_reg   <= msmc_pkg::MP_RAM_RESET;  // [RQ18]
            regPage_reg   <= msmc_pkg::MP_REG_RESET;  // [RQ19]
            placeDone_reg <= 1'b0;
        end else if (wrLow && hitPlace && placeOk) begin
            ramPage_reg   <= wbDatI[msmc_pkg::MP_RAM_LSB +: 4];
            regPage_reg   <= wbDatI[msmc_pkg::MP_REG_LSB +: 4];
            placeDone_reg <= 1'b1;                    // [RQ17]
        end
    end

    // ****************************************
    // read mux and acknowledge
    // ****************************************
    logic [7:0] rdByte;

    always_comb begin
        rdByte = 8'h00;
        if (hitMode) begin
            rdByte = {bootEn_reg && special_reg, special_reg, expand_reg,  // [RQ4]
                      visible_reg, psel_reg};
        end else if (hitPlace) begin
            rdByte = {ramPage_reg, regPage_reg};
        end else if (hitOpts) begin
            rdByte = 8'h00;                                        // [RQ13]
            rdByte[msmc_pkg::SO_WDOG_DIS_BIT] = wdogDis_reg;
            rdByte[msmc_pkg::SO_ROM_BIT]      = rom_present_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wbAckO <= 1'b0;
            wbDatO <= 32'h0000_0000;
        end else begin
            wbAckO <= busReq;
            if (busReq && !wbWeI) begin
                wbDatO <= {24'h00_0000, rdByte};
            end
        end
    end

    // ****************************************
    // E pin and fetch strobe
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eClkOut     <= 1'b0;
            strapAPinOe <= 1'b0;
        end else begin
            eClkOut <= (divCnt_reg >= DIV_HALF)
                       && (expand_reg || !visible_reg);            // [RQ8] [RQ9]
            if (eTick) begin
                strapAPinOe <= opcodeFetch;                          // [RQ3]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        strapAPinOut <= 1'b0;                                        // [RQ3]
    end

    // ****************************************
    // internal read visibility
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            extDataOe  <= 1'b0;
            extDataOut <= 8'h00;
        end else begin
            extDataOe  <= expand_reg && visible_reg && intReadAccess;  // [RQ7]
            extDataOut <= intReadData;
        end
    end

    // ****************************************
    // address decoder
    // ****************************************
    logic       hitReg;
    logic       hitRam;
    logic       hitRom;
    logic       hitBoot;
    logic [3:0] romPage;

    assign romPage = resetExpanded_reg ? msmc_pkg::ROM_PAGE_EXPANDED
                                       : msmc_pkg::ROM_PAGE_OTHER;          // [RQ16]
    assign hitReg  = (cpuAddr[15:12] == regPage_reg)
                     && (cpuAddr[11:0] <= msmc_pkg::REG_LAST_LOW);          // [RQ19]
    assign hitRam  = (cpuAddr[15:12] == ramPage_reg) && (cpuAddr[11:8] == 4'h0)
                     && (cpuAddr[7:0] >= msmc_pkg::RAM_FIRST_LOW)
                     && (cpuAddr[7:0] <= msmc_pkg::RAM_LAST_LOW);           // [RQ18]
    assign hitRom  = rom_present_reg && (cpuAddr[15:12] == romPage);              // [RQ15]
    assign hitBoot = bootEn_reg && special_reg
                     && (cpuAddr >= msmc_pkg::BOOT_FIRST)
                     && (cpuAddr <= msmc_pkg::BOOT_LAST);                   // [RQ4]

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            selRegBlock <= 1'b0;
            selRam      <= 1'b0;
            selRom      <= 1'b0;
            selBootRom  <= 1'b0;
        end else begin
            selRegBlock <= hitReg;
            selRam      <= hitRam && !hitReg;                   // [RQ21]
            selRom      <= hitRom && !hitReg && !hitRam;        // [RQ20]
            selBootRom  <= hitBoot && !hitReg && !hitRam;       // [RQ20]
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            watchdogDisable <= 1'b0;
            specialMode     <= 1'b0;
            expandedMode    <= 1'b0;
        end else begin
            watchdogDisable <= wdogDis_reg;  // [RQ14]
            specialMode     <= special_reg;
            expandedMode    <= expand_reg;
        end
    end

endmodule

/* File: verification/msmc_strap_model.sv */
`timescale 1ns/10ps
// ****
// board straps, strap A through pull resistor
// ****
module msmc_strap_model (
    // board setting, B in bit 1
    input  wire logic [1:0] strapMode,
    // strap A pin drivers
    input  wire logic       strapAPinOut,
    input  wire logic       strapAPinOe,
    // pin levels
    output logic            strapA,
    output logic            strapB
);
    assign strapA = strapAPinOe ? strapAPinOut : strapMode[0];
    assign strapB = strapMode[1];
endmodule

/* File: verification/msmc_config_sva.sv */
`timescale 1ns/10ps
// ****
// checker
// ****
module msmc_config_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // bus
    input wire logic        wbCycI,
    input wire logic        wbStbI,
    input wire logic        wbAckO,
    // pins
    input wire logic        strapAPinOut,
    input wire logic        intReadAccess,
    input wire logic [7:0]  intReadData,
    input wire logic [15:0] cpuAddr,
    input wire logic [7:0]  extDataOut,
    input wire logic        extDataOe,
    // decode and status
    input wire logic        selRegBlock,
    input wire logic        selRam,
    input wire logic        selRom,
    input wire logic        selBootRom,
    input wire logic        specialMode,
    input wire logic        expandedMode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_ack_next: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
        else $error("ack missing after request");
    chk_strobe_low: assert property (strapAPinOut == 1'b0)
        else $error("strap A driven high");
    chk_vis_data: assert property (extDataOe |-> $past(intReadAccess) && expandedMode
        && extDataOut == $past(intReadData)) else $error("bad read visibility");
    chk_decode_onehot: assert property ($onehot0({selRegBlock, selRam, selRom, selBootRom}))
        else $error("two selects at once");
    chk_reg_window: assert property (selRegBlock |-> $past(cpuAddr[11:6]) == 6'h00)
        else $error("register block out of window");
    chk_ram_window: assert property (selRam |-> $past(cpuAddr[11:8]) == 4'h0
        && $past(cpuAddr[7:6]) != 2'b00) else $error("ram out of window");
    chk_rom_page: assert property (selRom |-> $past(cpuAddr[15:12]) inside {4'h7, 4'hf})
        else $error("rom on wrong page");
    chk_boot_window: assert property (selBootRom |-> specialMode && $past(cpuAddr[15:8]) == 8'hbf
        && $past(cpuAddr[7:0]) >= 8'h40) else $error("boot rom misdecoded");
    chk_special_sticky: assert property (!specialMode && !$past(srst) |=> !specialMode)
        else $error("special bit set again");
    chk_expand_lock: assert property (!specialMode && !$past(srst) |=> $stable(expandedMode))
        else $error("expanded bit moved in normal mode");
endmodule

bind msmc_config msmc_config_sva chk_u (.clk_sys, .srst, .wbCycI, .wbStbI, .wbAckO,
    .strapAPinOut, .intReadAccess, .intReadData, .cpuAddr, .extDataOut, .extDataOe,
    .selRegBlock, .selRam, .selRom, .selBootRom, .specialMode, .expandedMode);

/* File: verification/msmc_config_tb.sv */
`timescale 1ns/10ps
module msmc_config_tb;
    // ****
    // signals
    // ****
    logic        clk_sys = 1'b0, srst = 1'b1, wbCycI = 1'b0, wbStbI = 1'b0, wbWeI = 1'b0;
    logic        opcodeFetch = 1'b0, intReadAccess = 1'b0, eSeen;
    logic [9:0]  wbAdrI = 10'h000;
    logic [3:0]  wbSelI = 4'h0, romPg;
    logic [31:0] wbDatI = 32'h00000000, wbDatO;
    logic [7:0]  intReadData = 8'h00, extDataOut, rd, pm, mp, so;
    logic [15:0] cpuAddr = 16'h0000;
    logic [1:0]  strapMode = 2'b10;
    logic        wbAckO, strapA, strapB, strapAPinOut, strapAPinOe, extDataOe, eClkOut;
    logic        selRegBlock, selRam, selRom, selBootRom, watchdogDisable, specialMode;
    logic        expandedMode;
    int          errorCnt = 0, totalChecks = 0;

    always #10 clk_sys = ~clk_sys;

    msmc_config #(.E_DIV(4)) dut_u (.clk_sys(clk_sys), .srst(srst), .wbCycI(wbCycI),
        .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAckO(wbAckO), .strapAPinIn(strapA), .strapBPinIn(strapB),
        .strapAPinOut(strapAPinOut), .strapAPinOe(strapAPinOe), .opcodeFetch(opcodeFetch),
        .intReadAccess(intReadAccess), .intReadData(intReadData), .cpuAddr(cpuAddr),
        .extDataOut(extDataOut), .extDataOe(extDataOe), .eClkOut(eClkOut),
        .selRegBlock(selRegBlock), .selRam(selRam), .selRom(selRom), .selBootRom(selBootRom),
        .watchdogDisable(watchdogDisable), .specialMode(specialMode),
        .expandedMode(expandedMode));
    msmc_strap_model model_u (.strapMode(strapMode), .strapAPinOut(strapAPinOut),
        .strapAPinOe(strapAPinOe), .strapA(strapA), .strapB(strapB));

    // ****
    // expectations
    // ****
    function automatic logic [7:0] exp_pm(input logic [1:0] m);
        return {~m[1] & ~m[0], ~m[1], m[0], ~m[1] & m[0], 4'h5};
    endfunction
    function automatic logic [3:0] exp_sel(input logic [15:0] a);
        logic rg, rm;
        rg = a[15:12] == mp[3:0] && a[11:6] == 6'h00;
        rm = !rg && a[15:12] == mp[7:4] && a[11:8] == 4'h0 && a[7:6] != 2'b00;
        return {rg, rm, !rg && !rm && so[1] && a[15:12] == romPg,
            !rg && !rm && pm[7] && pm[6] && a[15:8] == 8'hbf && a[7:0] >= 8'h40};
    endfunction

    // ****
    // tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        wbWeI  <= we;
        wbSelI <= 4'h1;
        wbAdrI <= {idx, 2'b00};
        wbDatI <= {24'h000000, d};
        @(posedge clk_sys);
        #1;
        while (wbAckO !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 20) errorCnt++;
        @(posedge clk_sys);
        rd = wbDatO[7:0];
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
    endtask
    task automatic probe(input logic [15:0] a);
        @(posedge clk_sys);
        cpuAddr <= a;
        @(posedge clk_sys);
        #1;
        check({4'h0, selRegBlock, selRam, selRom, selBootRom}, {4'h0, exp_sel(a)});
    endtask
    task automatic e_watch();
        eSeen = 1'b0;
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            eSeen |= eClkOut;
        end
    endtask
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk_sys);
        strapMode <= m;
        srst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #200000;
        errorCnt++;
        wrap_up();
    end

    // ****
    // tests
    // ****
    initial begin
        logic [15:0] a;
        logic [15:0] cor [8];
        void'($urandom(612));
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            @(posedge clk_sys);
            strapMode <= ~strapMode;
            pm = exp_pm(m[1:0]);
            mp = 8'h00;
            so = 8'h02;
            romPg = (m == 3) ? 4'h7 : 4'hf;
            repeat (4) @(posedge clk_sys);
            #1;
            check(specialMode, pm[6]);
            check(expandedMode, pm[5]);
            wb(1'b0, msmc_pkg::IDX_PRIORITY_AND_MODE, 8'h00);
            check(rd, pm);
            wb(1'b0, msmc_pkg::IDX_STARTUP_OPTIONS, 8'h00);
            check(rd, so);
            wb(1'b0, msmc_pkg::IDX_MEMORY_PLACEMENT, 8'h00);
            check(rd, mp);
            e_watch();
            check(eSeen, 1'b1);
            probe({romPg, 12'h800});
            probe({~romPg, 12'h800});
            // ram or register page on the rom page, rom kept on
            wb(1'b1, msmc_pkg::IDX_MEMORY_PLACEMENT, {romPg, 4'h1});
            wb(1'b1, msmc_pkg::IDX_MEMORY_PLACEMENT, {4'h4, romPg});
            wb(1'b1, msmc_pkg::IDX_STARTUP_OPTIONS, 8'hff);
            wb(1'b1, msmc_pkg::IDX_STARTUP_OPTIONS, 8'h03);
            mp = pm[6] ? {4'h4, romPg} : {romPg, 4'h1};
            so = pm[6] ? 8'h02 : 8'h06;
            wb(1'b0, msmc_pkg::IDX_MEMORY_PLACEMENT, 8'h00);
            check(rd, mp);
            wb(1'b0, msmc_pkg::IDX_STARTUP_OPTIONS, 8'h00);
            check(rd, so);
            check(watchdogDisable, so[2]);
            cor = '{{mp[3:0], 12'h000}, {mp[3:0], 12'h03f}, {mp[7:4], 12'h040},
                {mp[7:4], 12'h0ff}, 16'hbf40, 16'hbfff, 16'hbf3f, {mp[3:0], 12'h040}};
            for (int i = 0; i < 28; i++) begin
                a = 16'($urandom);
                if (a[0]) a[11:8] = 4'h0;
                probe(i < 8 ? cor[i] : a);
            end
            wb(1'b1, msmc_pkg::IDX_PRIORITY_AND_MODE, 8'hb5);
            pm = pm[6] ? 8'h35 : {2'b00, pm[5], 1'b1, 4'h5};
            wb(1'b0, msmc_pkg::IDX_PRIORITY_AND_MODE, 8'h00);
            check(rd, pm);
            intReadAccess <= 1'b1;
            intReadData <= 8'($urandom);
            probe(16'hbf80);
            probe({romPg, 12'h900});
            probe({romPg ^ 4'h8, 12'h900});
            e_watch();
            check(eSeen, pm[5]);
            check(extDataOe, pm[5]);
            if (pm[5]) check(extDataOut, intReadData);
            @(posedge clk_sys);
            intReadAccess <= 1'b0;
            opcodeFetch <= 1'b1;
            e_watch();
            check({strapAPinOe, strapA}, 2'b10);
            @(posedge clk_sys);
            opcodeFetch <= 1'b0;
            e_watch();
            check(strapAPinOe, 1'b0);
        end
        // last accepted write edge lies 64 E cycles of 4 clocks after release
        for (int k = 0; k < 2; k++) begin
            do_reset(2'b10);
            repeat (msmc_pkg::WINDOW_BUS_CYCLES * 4 - 2 - k) @(posedge clk_sys);
            wb(1'b1, msmc_pkg::IDX_MEMORY_PLACEMENT, 8'h11);
            wb(1'b0, msmc_pkg::IDX_MEMORY_PLACEMENT, 8'h00);
            check(rd, (k == 1) ? 8'h11 : 8'h00);
        end
        wrap_up();
    end
endmodule
